// ### sim/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
	import door_cfg_pkg::*;
(
	// clock
	input  wire logic              clk,
	// register port
	output logic      [ADDR_W-1:0] reg_addr,
	output logic      [DATA_W-1:0] reg_wdata,
	output logic                   reg_wr,
	output logic                   reg_rd,
	input  wire logic [DATA_W-1:0] reg_rdata,
	input  wire logic              reg_hit,
	// supply flag clears
	output logic                   supply_over_clear,
	output logic                   supply_under_clear
);
	initial begin
		reg_addr           = '0;
		reg_wdata          = '0;
		reg_wr             = 1'b0;
		reg_rd             = 1'b0;
		supply_over_clear  = 1'b0;
		supply_under_clear = 1'b0;
	end

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		// released data must not keep showing the last word
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] d,
			output logic h);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
		h = reg_hit;
	endtask

	// latched supply flags only go away when the host clears them
	task automatic clr_supply();
		@(posedge clk);
		supply_over_clear  <= 1'b1;
		supply_under_clear <= 1'b1;
		@(posedge clk);
		supply_over_clear  <= 1'b0;
		supply_under_clear <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import door_cfg_pkg::*;
;
	logic              clk;
	logic              rst;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic              reg_hit;
	logic              pa;
	logic              pb;
	logic [NCH-1:0]    ocd;
	logic              sov;
	logic              suv;
	logic [NCH-1:0]    drv_en;
	logic [3:0]        ipulse;
	logic [1:0]        lamp7;
	logic [1:0]        lamp8;
	logic [5:0]        dac;
	logic [NCH-1:0]    oc_clr;
	logic              sov_clr;
	logic              suv_clr;
	logic [NCH-1:0]    oen;
	logic [NCH-1:0]    ocf;
	logic              gflt;
	logic              ovf;
	logic              uvf;
	logic              unit_en;
	logic [NCH-1:0]    sense;
	logic [5:0]        dac_lvl;
	int                err_count;
	int                compares;
	int                n;
	logic [11:0]       sense_exp [16] = '{12'h001, 12'h000, 12'h000,
		12'h008, 12'h010, 12'h020, 12'h080, 12'h100, 12'h200, 12'h400,
		12'h800, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};

	// --------------------------------------------------------------
	// design and host
	// --------------------------------------------------------------
	// short retry delays keep the run brief
	output_control_regs #(.SLOW_CYC(20), .FAST_CYC(5)) i_dut (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_hit(reg_hit), .pulse_input_a(pa), .pulse_input_b(pb),
		.overcurrent_detect(ocd), .supply_over_detect(sov),
		.supply_under_detect(suv), .driver_enable(drv_en),
		.internal_pulse(ipulse), .lamp_mode_field_7(lamp7),
		.lamp_mode_field_8(lamp8), .dac_code(dac),
		.overcurrent_flag_clear(oc_clr), .supply_over_clear(sov_clr),
		.supply_under_clear(suv_clr), .output_enable(oen),
		.output_overcurrent_flag(ocf), .global_fault_flag(gflt),
		.supply_overvoltage_flag(ovf), .supply_undervoltage_flag(uvf),
		.internal_pulse_unit_enable(unit_en), .sense_route(sense),
		.mirror_dac_level(dac_lvl));

	host_model i_host (
		.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_hit(reg_hit), .supply_over_clear(sov_clr),
		.supply_under_clear(suv_clr));

	always #2.5 clk = ~clk;

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic print_verdict();
		if (err_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask

	// ends just after an edge so outputs have settled
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic rchk(input logic [4:0] a, input logic [15:0] e,
			input logic eh);
		logic [15:0] d;
		logic        h;
		i_host.rd(a, d, h);
		chk(d, e);
		chk({15'h0, h}, {15'h0, eh});
	endtask

	task automatic clear_oc();
		@(posedge clk);
		oc_clr <= '1;
		@(posedge clk);
		oc_clr <= '0;
		cyc(6);
	endtask

	// fault on one channel, then count cycles until it conducts again
	task automatic retry(input int ch, output int k);
		@(posedge clk);
		ocd[ch] <= 1'b1;
		cyc(6);
		chk({15'h0, oen[ch]}, 16'h0);
		chk({15'h0, ocf[ch]}, 16'h1);
		chk({15'h0, gflt}, 16'h1);
		@(posedge clk);
		ocd[ch] <= 1'b0;
		k = 0;
		while (k < 60 && oen[ch] !== 1'b1) begin
			cyc(1);
			k++;
		end
	endtask

	// --------------------------------------------------------------
	// tests
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{pa, pb, sov, suv, ipulse, dac, ocd, oc_clr} = '0;
		drv_en = '1;
		lamp7  = 2'h1;
		lamp8  = 2'h1;
		err_count = 0;
		compares  = 0;
		cyc(12);
		rst <= 1'b0;
		rchk(5'h02, 16'h0000, 1'b1);
		rchk(5'h03, 16'h0000, 1'b1);
		i_host.wr(5'h04, 16'hffff);
		rchk(5'h04, 16'h0000, 1'b0);
		i_host.wr(5'h02, 16'ha5c3);
		i_host.wr(5'h03, 16'h5a3c);
		rchk(5'h02, 16'ha5c3, 1'b1);
		rchk(5'h03, 16'h5a3c, 1'b1);
		i_host.wr(5'h02, 16'h0000);
		i_host.wr(5'h03, 16'h0000);
		cyc(6);
		chk(16'(oen), 16'h0fff);
		@(posedge clk);
		drv_en <= 12'h5a5;
		cyc(3);
		chk(16'(oen), 16'h05a5);
		@(posedge clk);
		drv_en <= '1;
		retry(0, n);
		chk(16'(n), 16'd60);
		clear_oc();
		chk({15'h0, gflt}, 16'h0);
		chk({15'h0, oen[0]}, 16'h1);
		// a clear while the fault is still present must not win
		@(posedge clk);
		ocd[0] <= 1'b1;
		cyc(4);
		clear_oc();
		chk({15'h0, ocf[0]}, 16'h1);
		chk({15'h0, oen[0]}, 16'h0);
		@(posedge clk);
		ocd[0] <= 1'b0;
		cyc(3);
		clear_oc();
		chk({15'h0, ocf[0]}, 16'h0);
		i_host.wr(5'h02, 16'h8000);
		retry(0, n);
		chk({15'h0, n >= 12 && n < 40}, 16'h1);
		clear_oc();
		i_host.wr(5'h03, 16'h0020);
		retry(0, n);
		chk({15'h0, n < 12}, 16'h1);
		clear_oc();
		@(posedge clk);
		lamp7 <= 2'h2;
		i_host.wr(5'h03, 16'h8020);
		retry(7, n);
		chk({15'h0, n >= 12 && n < 40}, 16'h1);
		clear_oc();
		i_host.wr(5'h02, 16'h00fe);
		i_host.wr(5'h03, 16'h07c0);
		@(posedge clk);
		pa <= 1'b1;
		cyc(6);
		chk(16'(oen), 16'h0aef);
		@(posedge clk);
		pa <= 1'b0;
		pb <= 1'b1;
		cyc(6);
		chk(16'(oen), 16'h0510);
		@(posedge clk);
		pb     <= 1'b0;
		ipulse <= 4'h5;
		i_host.wr(5'h02, 16'h01fe);
		cyc(6);
		chk(16'(oen), 16'h0280);
		chk({15'h0, unit_en}, 16'h1);
		i_host.wr(5'h02, 16'h0000);
		@(posedge clk);
		dac <= 6'h3f;
		cyc(4);
		chk({10'h0, dac_lvl}, 16'h0033);
		i_host.wr(5'h02, 16'h0001);
		cyc(4);
		chk({10'h0, dac_lvl}, 16'h003f);
		for (int c = 0; c < 16; c++) begin
			i_host.wr(5'h03, 16'(c));
			cyc(3);
			chk(16'(sense), 16'(sense_exp[c]));
		end
		i_host.wr(5'h03, 16'h0000);
		@(posedge clk);
		suv <= 1'b1;
		cyc(6);
		chk({15'h0, uvf}, 16'h1);
		chk(16'(oen), 16'h0000);
		@(posedge clk);
		suv <= 1'b0;
		cyc(6);
		chk({15'h0, uvf}, 16'h0);
		i_host.wr(5'h03, 16'h0010);
		@(posedge clk);
		sov <= 1'b1;
		cyc(6);
		@(posedge clk);
		sov <= 1'b0;
		cyc(6);
		chk({15'h0, ovf}, 16'h1);
		i_host.clr_supply();
		cyc(4);
		chk({15'h0, ovf}, 16'h0);
		print_verdict();
	end

	// a hang ends the run as a failure
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire

// ### src/door_cfg_pkg.sv
// Behaviour
// - overcurrent switches its output off, sets its flag and the global fault flag.
// - per-output retry enable, reset clear; set re-enables output after the retry delay.
// - retry rate bit: 0 slow retry (default), 1 fast retry.
// - retry rate bit is ignored for lamp outputs 7 and 8 in bulb mode.
// - two external pulse pins plus internal pulse unit, enabled by a reset-clear bit.
// - selected half-bridge output conducts only while its pulse pin is high.
// - half-bridge 5 gated by pin b; others and mirror pull-down by pin a.
// - mirror reference is code*1.5/64, clamped to 1.2 V unless full scale set.
// - selected high-side output gated by its source; internal unit only for 7 to 10.
// - high-side 8 and 10 gated by pin b; 7, 9 and 11 by pin a.
// - supply fault bit 0 recovers automatically; 1 latches supply flags until cleared.
// - sense select routes outputs 1 and 4 to 11; other codes switch sensing off.
// - selected mirror pull-down conducts only while pulse pin a is high.
// - lamp mode 01 led, 10 bulb, 00 and 11 high impedance.
package door_cfg_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int          ADDR_W     = 5;
	localparam int          DATA_W     = 16;
	localparam logic [4:0]  ADDR_CFG2  = 5'h02;
	localparam logic [4:0]  ADDR_CFG3  = 5'h03;
	localparam logic [15:0] CFG_RESET  = 16'h0000;

	// recovery_and_bridge_pwm_config fields
	localparam int OCR_HB_LSB      = 10;
	localparam int OCR_MIRROR_BIT  = 9;
	localparam int PULSE_UNIT_BIT  = 8;
	localparam int HB_GATE_LSB     = 2;
	localparam int MIRROR_GATE_BIT = 1;
	localparam int FULL_SCALE_BIT  = 0;

	// highside_pwm_and_sense_config fields
	localparam int OCR_HS_LSB      = 11;
	localparam int HS_GATE_LSB     = 6;
	localparam int RATE_BIT        = 5;
	localparam int SUPPLY_BIT      = 4;
	localparam int SENSE_LSB       = 0;

	// ------------------------------------------------------------
	// channels: 0..5 half-bridge 1..6, 6 mirror pull-down, 7..11 hs 7..11
	// ------------------------------------------------------------
	localparam int          NCH        = 12;
	localparam int          CH_LAMP7   = 7;
	localparam int          CH_LAMP8   = 8;
	localparam logic [11:0] PIN_B_MASK = 12'h510;
	localparam logic [11:0] UNIT_MASK  = 12'h780;

	localparam logic [1:0]  LAMP_BULB  = 2'h2;

	// 1.2 V * 64 / 1.5 = 51.2, largest code at or below the clamp
	localparam logic [5:0]  DAC_CLAMP  = 6'h33;

	// ------------------------------------------------------------
	// retry timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 5;
	localparam int SLOW_RETRY_NS   = 1000000;
	localparam int FAST_RETRY_NS   = 100000;
	localparam int SLOW_RETRY_CYC  = SLOW_RETRY_NS / CLK_PERIOD_NS;
	localparam int FAST_RETRY_CYC  = FAST_RETRY_NS / CLK_PERIOD_NS;
	localparam int RETRY_CNT_W     = 20;

endpackage

// ### src/output_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module output_control_regs
	import door_cfg_pkg::*;
#(
	parameter int SLOW_CYC = SLOW_RETRY_CYC,
	parameter int FAST_CYC = FAST_RETRY_CYC
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   reg_hit,
	// pins, asynchronous
	input  wire logic              pulse_input_a,
	input  wire logic              pulse_input_b,
	input  wire logic [NCH-1:0]    overcurrent_detect,
	input  wire logic              supply_over_detect,
	input  wire logic              supply_under_detect,
	// other control logic, same clock
	input  wire logic [NCH-1:0]    driver_enable,
	input  wire logic [3:0]        internal_pulse,
	input  wire logic [1:0]        lamp_mode_field_7,
	input  wire logic [1:0]        lamp_mode_field_8,
	input  wire logic [5:0]        dac_code,
	input  wire logic [NCH-1:0]    overcurrent_flag_clear,
	input  wire logic              supply_over_clear,
	input  wire logic              supply_under_clear,
	// results
	output logic      [NCH-1:0]    output_enable,
	output logic      [NCH-1:0]    output_overcurrent_flag,
	output logic                   global_fault_flag,
	output logic                   supply_overvoltage_flag,
	output logic                   supply_undervoltage_flag,
	output logic                   internal_pulse_unit_enable,
	output logic      [NCH-1:0]    sense_route,
	output logic      [5:0]        mirror_dac_level
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic [NCH-1:0] decode_sense(input logic [3:0] code);
		logic [NCH-1:0] r;
		r = '0;
		case (code)
			4'h0:    r[0] = 1'b1;
			4'h3:    r[3] = 1'b1;
			4'h4:    r[4] = 1'b1;
			4'h5:    r[5] = 1'b1;
			4'h6:    r[7] = 1'b1;
			4'h7:    r[8] = 1'b1;
			4'h8:    r[9] = 1'b1;
			4'h9:    r[10] = 1'b1;
			4'ha:    r[11] = 1'b1;
			default: r = '0;
		endcase
		return r;
	endfunction

	logic [DATA_W-1:0] cfg2_reg;
	logic [DATA_W-1:0] cfg3_reg;

	logic [NCH-1:0] oc_s1_reg;
	logic [NCH-1:0] oc_s2_reg;
	logic           pa_s1_reg;
	logic           pa_s2_reg;
	logic           pb_s1_reg;
	logic           pb_s2_reg;
	logic           ov_s1_reg;
	logic           ov_s2_reg;
	logic           uv_s1_reg;
	logic           uv_s2_reg;

	logic [NCH-1:0] shut_reg;
	logic [NCH-1:0] shut_next;
	logic [NCH-1:0] shut_q_reg;
	logic [NCH-1:0] retry_done;
	logic [NCH-1:0] retry_en;
	logic [NCH-1:0] gate_sel;
	logic [NCH-1:0] fast_sel;
	logic [NCH-1:0] src_vec;
	logic [NCH-1:0] unit_vec;
	logic [NCH-1:0] oc_flag_next;
	logic           rate_fast;
	logic           latch_supply;
	logic           supply_block;
	logic           ov_next;
	logic           uv_next;

	// ------------------------------------------------------------
	// register writes and reads
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg2_reg <= CFG_RESET;
			cfg3_reg <= CFG_RESET;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_CFG2)
				cfg2_reg <= reg_wdata;
			if (reg_addr == ADDR_CFG3)
				cfg3_reg <= reg_wdata;
		end
	end

	// addresses outside this pair read zero and leave reg_hit low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
			reg_hit   <= 1'b0;
		end else if (reg_rd) begin
			reg_hit <= (reg_addr == ADDR_CFG2) || (reg_addr == ADDR_CFG3);
			if (reg_addr == ADDR_CFG2)
				reg_rdata <= cfg2_reg;
			else if (reg_addr == ADDR_CFG3)
				reg_rdata <= cfg3_reg;
			else
				reg_rdata <= '0;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oc_s1_reg <= '0;
			oc_s2_reg <= '0;
			{pa_s1_reg, pb_s1_reg, ov_s1_reg, uv_s1_reg} <= 4'h0;
			{pa_s2_reg, pb_s2_reg, ov_s2_reg, uv_s2_reg} <= 4'h0;
		end else begin
			oc_s1_reg <= overcurrent_detect;
			oc_s2_reg <= oc_s1_reg;
			{pa_s1_reg, pb_s1_reg} <= {pulse_input_a, pulse_input_b};
			{pa_s2_reg, pb_s2_reg} <= {pa_s1_reg, pb_s1_reg};
			{ov_s1_reg, uv_s1_reg} <=
				{supply_over_detect, supply_under_detect};
			{ov_s2_reg, uv_s2_reg} <= {ov_s1_reg, uv_s1_reg};
		end
	end

	// ------------------------------------------------------------
	// per-channel field gathering
	// ------------------------------------------------------------
	always_comb begin
		retry_en = '0;
		gate_sel = '0;
		for (int i = 0; i < 6; i++) begin
			retry_en[i] = cfg2_reg[OCR_HB_LSB + 5 - i];
			gate_sel[i] = cfg2_reg[HB_GATE_LSB + 5 - i];
		end
		retry_en[6] = cfg2_reg[OCR_MIRROR_BIT];
		gate_sel[6] = cfg2_reg[MIRROR_GATE_BIT];
		for (int i = 0; i < 5; i++) begin
			retry_en[7 + i] = cfg3_reg[OCR_HS_LSB + 4 - i];
			gate_sel[7 + i] = cfg3_reg[HS_GATE_LSB + 4 - i];
		end
	end

	assign rate_fast    = cfg3_reg[RATE_BIT];
	assign latch_supply = cfg3_reg[SUPPLY_BIT];

	// bulb mode keeps its own slow retry whatever the rate bit says
	always_comb begin
		fast_sel = {NCH{rate_fast}};
		if (lamp_mode_field_7 == LAMP_BULB)
			fast_sel[CH_LAMP7] = 1'b0;
		if (lamp_mode_field_8 == LAMP_BULB)
			fast_sel[CH_LAMP8] = 1'b0;
	end

	// ------------------------------------------------------------
	// overcurrent shutdown and retry
	// ------------------------------------------------------------
	// a fault still present when the delay ends restarts the count
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_retry
			retry_timer #(
				.SLOW_CYC (SLOW_CYC),
				.FAST_CYC (FAST_CYC)
			) u_timer (
				.clk   (clk),
				.rst   (rst),
				.start (shut_reg[g]
					& (~shut_q_reg[g] | (retry_done[g] & oc_s2_reg[g]))),
				.fast  (fast_sel[g]),
				.done  (retry_done[g])
			);
		end
	endgenerate

	// a live overcurrent holds the channel off over any release
	always_comb begin
		shut_next = shut_reg & ~(retry_done & retry_en)
			& ~overcurrent_flag_clear;
		shut_next = shut_next | oc_s2_reg;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shut_reg   <= '0;
			shut_q_reg <= '0;
		end else begin
			shut_reg   <= shut_next;
			shut_q_reg <= shut_reg;
		end
	end

	// ------------------------------------------------------------
	// status flags, set wins over clear
	// ------------------------------------------------------------
	assign oc_flag_next = (output_overcurrent_flag & ~overcurrent_flag_clear)
		| oc_s2_reg;

	always_comb begin
		if (latch_supply) begin
			ov_next = ov_s2_reg
				| (supply_overvoltage_flag & ~supply_over_clear);
			uv_next = uv_s2_reg
				| (supply_undervoltage_flag & ~supply_under_clear);
		end else begin
			ov_next = ov_s2_reg;
			uv_next = uv_s2_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			output_overcurrent_flag  <= '0;
			supply_overvoltage_flag  <= 1'b0;
			supply_undervoltage_flag <= 1'b0;
			global_fault_flag        <= 1'b0;
		end else begin
			output_overcurrent_flag  <= oc_flag_next;
			supply_overvoltage_flag  <= ov_next;
			supply_undervoltage_flag <= uv_next;
			global_fault_flag <= (|oc_flag_next) | ov_next | uv_next;
		end
	end

	// ------------------------------------------------------------
	// pulse gating
	// ------------------------------------------------------------
	assign supply_block = supply_overvoltage_flag | supply_undervoltage_flag;
	assign unit_vec     = {1'b0, internal_pulse, 7'h00};

	always_comb begin
		src_vec = (PIN_B_MASK & {NCH{pb_s2_reg}})
			| (~PIN_B_MASK & {NCH{pa_s2_reg}});
		if (cfg2_reg[PULSE_UNIT_BIT])
			src_vec = (src_vec & ~UNIT_MASK) | (unit_vec & UNIT_MASK);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			output_enable <= '0;
		else
			output_enable <= driver_enable & ~shut_reg
				& ~{NCH{supply_block}}
				& (~gate_sel | src_vec);
	end

	// ------------------------------------------------------------
	// pulse unit, sense route, mirror reference
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			internal_pulse_unit_enable <= 1'b0;
			sense_route                <= '0;
			mirror_dac_level           <= '0;
		end else begin
			internal_pulse_unit_enable <= cfg2_reg[PULSE_UNIT_BIT];
			sense_route <= decode_sense(cfg3_reg[SENSE_LSB +: 4]);
			if (!cfg2_reg[FULL_SCALE_BIT] && dac_code > DAC_CLAMP)
				mirror_dac_level <= DAC_CLAMP;
			else
				mirror_dac_level <= dac_code;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	oc_fault_set_a: assert property (
		(|oc_s2_reg) |=> global_fault_flag && (|output_overcurrent_flag))
		else $error("overcurrent did not raise fault flags");
	oc_off_a: assert property (
		(|oc_s2_reg) |=> ##1 ((output_enable & $past(oc_s2_reg, 2)) == '0))
		else $error("output stayed on during overcurrent");
	no_retry_hold_a: assert property (
		(shut_reg[0] && !retry_en[0] && !overcurrent_flag_clear[0])
		|=> shut_reg[0])
		else $error("shutdown released without retry or clear");
	flag_set_wins_a: assert property (
		(oc_s2_reg[0] && overcurrent_flag_clear[0])
		|=> output_overcurrent_flag[0])
		else $error("clear beat overcurrent flag set");
	bulb_rate_a: assert property (
		(lamp_mode_field_7 == LAMP_BULB && !shut_reg[CH_LAMP7]
		&& oc_s2_reg[CH_LAMP7]) |-> !fast_sel[CH_LAMP7])
		else $error("bulb lamp used fast retry");
	pin_b_gate_a: assert property (
		(gate_sel[4] && !pb_s2_reg) |=> !output_enable[4])
		else $error("bridge 5 on while pin b low");
	pulldown_gate_a: assert property (
		(gate_sel[6] && !pa_s2_reg) |=> !output_enable[6])
		else $error("pull-down on while pin a low");
	hs11_pin_a_a: assert property (
		(gate_sel[11] && !pa_s2_reg) |=> !output_enable[11])
		else $error("output 11 on while pin a low");
	hs8_pin_b_a: assert property (
		(gate_sel[CH_LAMP8] && !cfg2_reg[PULSE_UNIT_BIT] && !pb_s2_reg)
		|=> !output_enable[CH_LAMP8])
		else $error("output 8 on while pin b low");
	dac_clamp_a: assert property (
		(!cfg2_reg[FULL_SCALE_BIT]) |=> (mirror_dac_level <= DAC_CLAMP))
		else $error("mirror level above clamp");
	supply_latch_a: assert property (
		(latch_supply && supply_overvoltage_flag && !supply_over_clear)
		|=> supply_overvoltage_flag)
		else $error("latched overvoltage flag dropped");
	sense_off_a: assert property (
		(cfg3_reg[SENSE_LSB +: 4] > 4'ha) ##1 $stable(cfg3_reg)
		|-> (sense_route == '0))
		else $error("sense active on an off code");

endmodule
`default_nettype wire

// ### src/retry_timer.sv
`timescale 1ns/1ps
`default_nettype none
module retry_timer
	import door_cfg_pkg::*;
#(
	parameter int SLOW_CYC = SLOW_RETRY_CYC,
	parameter int FAST_CYC = FAST_RETRY_CYC
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic start,
	input  wire logic fast,
	// result
	output logic      done
);

	logic [RETRY_CNT_W-1:0] cnt_reg;
	logic                   run_reg;

	// ------------------------------------------------------------
	// delay count, restarted by every start
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else if (start) begin
			cnt_reg <= fast ? RETRY_CNT_W'(FAST_CYC) : RETRY_CNT_W'(SLOW_CYC);
			run_reg <= 1'b1;
		end else if (run_reg) begin
			cnt_reg <= cnt_reg - 1'b1;
			if (cnt_reg == RETRY_CNT_W'(1))
				run_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			done <= 1'b0;
		else
			done <= run_reg && !start && (cnt_reg == RETRY_CNT_W'(1));
	end

endmodule
`default_nettype wire
